// ---- src/steer_regs.vh ----
// register offsets, field positions, reset values and timing counts for io steering
`ifndef STEER_REGS_VH
`define STEER_REGS_VH
`define OFS_CTRL 4'h0
`define OFS_CHCFG 4'h1
`define OFS_STATIC_DIR 4'h2
`define OFS_STATIC_OUT 4'h3
`define OFS_STATUS 4'h4
`define OFS_TX_DATA 4'h5
`define OFS_RX_DATA 4'h6
`define OFS_DIVIDER 4'h7
`define CTRL_LOADED 0
`define CTRL_CLK_INTERNAL 1
`define CTRL_SYNC_MODE 2
`define CTRL_ENGINE_EN 3
`define CHCFG_DIR0 0
`define CHCFG_DIR1 1
`define CHCFG_HS0 2
`define CHCFG_HS1 3
`define CHCFG_LINE0 4
`define CHCFG_LINE1 6
`define LINE_RS232 2'h0
`define LINE_RS485 2'h1
`define LINE_ADJ 2'h2
`define CTRL_RESET 32'h0000_0000
`define CHCFG_RESET 32'h0000_0001
`define DIVIDER_RESET 16'h0019
`define ASYNC_OVERSAMPLE 8'h10
`define STATUS_TX_BUSY0 0
`define STATUS_RX_VALID0 2
`define STATUS_CTS0 4
`endif

// ---- src/bit_sync.v ----
// two flip-flop synchroniser for a bundle of pin inputs
module bit_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// lines
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // bit_sync

// ---- src/serial_lane.v ----
// one serial channel: shift engine with start gate, async or clock-edge timing
`include "steer_regs.vh"
module serial_lane (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// configuration
	input wire enable,
	input wire is_output,
	input wire sync_mode,
	input wire [15:0] divider,
	input wire bit_tick_sync,
	input wire send_gate,
	// parallel side
	input wire [15:0] tx_word,
	input wire tx_start,
	output reg tx_busy,
	output reg [15:0] rx_word,
	output reg rx_done,
	// serial side
	input wire serial_in,
	output reg serial_out
);
	reg [15:0] cnt_r;
	reg [4:0] bits_r;
	reg [15:0] shift_r;
	reg rx_busy_r;
	reg prev_in_r;
	wire tick_async = (cnt_r == 16'h0000);
	wire tick = sync_mode ? bit_tick_sync : tick_async;
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 16'h0000;
			bits_r <= 5'h00;
			shift_r <= 16'h0000;
			tx_busy <= 1'b0;
			rx_busy_r <= 1'b0;
			rx_word <= 16'h0000;
			rx_done <= 1'b0;
			serial_out <= 1'b1;
			prev_in_r <= 1'b1;
		end else begin
			rx_done <= 1'b0;
			prev_in_r <= serial_in;
			cnt_r <= tick_async ? divider : cnt_r - 16'h0001;
			if (!enable) begin
				tx_busy <= 1'b0;
				rx_busy_r <= 1'b0;
				serial_out <= 1'b1;
			end else if (is_output) begin
				rx_busy_r <= 1'b0;
				if (!tx_busy && tx_start && send_gate) begin
					tx_busy <= 1'b1;
					shift_r <= tx_word;
					bits_r <= 5'h11;
					serial_out <= 1'b0;
					// restart the bit timer so the start bit is a full period
					cnt_r <= divider;
				end else if (tx_busy && tick && send_gate) begin
					if (bits_r == 5'h01) begin
						serial_out <= 1'b1;
						tx_busy <= 1'b0;
					end else begin
						serial_out <= shift_r[0];
						shift_r <= {1'b1, shift_r[15:1]};
					end
					bits_r <= bits_r - 5'h01;
				end
			end else begin
				tx_busy <= 1'b0;
				if (!rx_busy_r && prev_in_r && !serial_in) begin
					rx_busy_r <= 1'b1;
					bits_r <= 5'h11;
					cnt_r <= {1'b0, divider[15:1]};
				end else if (rx_busy_r && tick) begin
					if (bits_r == 5'h01) begin
						rx_busy_r <= 1'b0;
						// last data bit goes straight into the word
						rx_word <= {serial_in, shift_r[15:1]};
						rx_done <= 1'b1;
					end else if (bits_r != 5'h11) begin
						shift_r <= {serial_in, shift_r[15:1]};
					end
					bits_r <= bits_r - 5'h01;
				end
			end
		end
	end
endmodule // serial_lane

// ---- src/io_steering.v ----
// two-channel serial io steering with avalon-mm register access
`include "steer_regs.vh"
// Summary of operation
// RULE1 - two channels, each configured as input or output
// RULE2 - each channel shifts serial to parallel and gates activity by start logic
// RULE3 - rs-232 receive line sampled only for an input channel
// RULE4 - rs-232 transmit line driven only for an output channel; code keeps rs232_tx_oe high on both, input channel held at marking
// RULE5 - rs-485 transceiver transmits for output channel, receives for input
// RULE6 - one adjustable line per channel, a third for the clock
// RULE7 - clock line driven from internal clock or taken as external input
// RULE8 - adjustable serial line driven on output, received on input
// RULE9 - drive enable low exactly while adjustable serial line is driven
// RULE10 - rts asserted while channel is ready to accept serial data
// RULE11 - with handshaking on, transmit only while remote holds cts
// RULE12 - eight static lines, each input or output
// RULE13 - before configuration loaded, only rs-232 transmitters drive, clock off
// RULE14 - default: channel0 output, channel1 input, async timing; sync selectable
// RULE15 - with handshaking off, transmit ignores cts
module io_steering (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// avalon-mm slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// rs-232 lines
	input wire [1:0] rs232_rx,
	output reg [1:0] rs232_tx,
	output reg [1:0] rs232_tx_oe,
	input wire [1:0] cts,
	output reg [1:0] rts,
	// rs-485 pairs
	input wire [1:0] rs485_rx,
	output reg [1:0] rs485_tx,
	output reg [1:0] rs485_tx_oe,
	// adjustable serial lines
	input wire [1:0] adjustable_serial_line_in,
	output reg [1:0] adjustable_serial_line_out,
	output reg [1:0] adjustable_serial_line_oe,
	output reg [1:0] line_drive_enable_n,
	// adjustable clock line
	input wire adjustable_clock_line_in,
	output reg adjustable_clock_line_out,
	output reg adjustable_clock_line_oe,
	// static lines
	input wire [7:0] static_io_lines_in,
	output reg [7:0] static_io_lines_out,
	output reg [7:0] static_io_lines_oe
);
	////////////////////////////////////////////////////////////////////////////
	reg [31:0] ctrl_r;
	reg [31:0] chcfg_r;
	reg [7:0] sdir_r;
	reg [7:0] sout_r;
	reg [15:0] div_r;
	reg [15:0] tx_word_r;
	reg [1:0] tx_start_r;
	reg [1:0] rx_valid_r;
	reg ack_r;
	reg [15:0] clk_cnt_r;
	reg int_clk_r;
	reg ext_clk_prev_r;
	wire [1:0] tx_busy;
	wire [1:0] rx_done;
	wire [15:0] rx_word0;
	wire [15:0] rx_word1;
	wire [1:0] rx_sel;
	wire [1:0] serial_tx;
	wire [7:0] static_in_s;
	wire [1:0] rs232_rx_s;
	wire [1:0] rs485_rx_s;
	wire [1:0] adj_in_s;
	wire [1:0] cts_s;
	wire ext_clk_s;
	wire loaded = ctrl_r[`CTRL_LOADED];
	wire [1:0] dir = {chcfg_r[`CHCFG_DIR1], chcfg_r[`CHCFG_DIR0]};
	wire [1:0] hs = {chcfg_r[`CHCFG_HS1], chcfg_r[`CHCFG_HS0]};
	wire [1:0] sel0 = chcfg_r[`CHCFG_LINE0+1:`CHCFG_LINE0];
	wire [1:0] sel1 = chcfg_r[`CHCFG_LINE1+1:`CHCFG_LINE1];
	wire clk_internal = ctrl_r[`CTRL_CLK_INTERNAL];
	wire sync_mode = ctrl_r[`CTRL_SYNC_MODE];
	wire engine_en = ctrl_r[`CTRL_ENGINE_EN] & loaded;
	wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire wr_hit = avs_write & ~ack_r;
	wire rd_hit = avs_read & ~ack_r;
	////////////////////////////////////////////////////////////////////////////
	// synchronisers for every pin input
	bit_sync #(.WIDTH(17)) pin_sync (
		.mclk(mclk),
		.rstn(rstn),
		.async_in({static_io_lines_in, rs232_rx, rs485_rx, adjustable_serial_line_in,
			cts, adjustable_clock_line_in}),
		.sync_out({static_in_s, rs232_rx_s, rs485_rx_s, adj_in_s, cts_s, ext_clk_s})
	);
	////////////////////////////////////////////////////////////////////////////
	// avalon slave: one wait cycle, then ack
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= `CTRL_RESET;
			chcfg_r <= `CHCFG_RESET; // see RULE14
			sdir_r <= 8'h00;
			sout_r <= 8'h00;
			div_r <= `DIVIDER_RESET;
			tx_word_r <= 16'h0000;
			tx_start_r <= 2'h0;
			rx_valid_r <= 2'h0;
			ack_r <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			avs_waitrequest <= 1'b1;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
			tx_start_r <= tx_start_r & ~tx_busy;
			// set wins over clear
			rx_valid_r <= (rx_valid_r & ~rx_sel) | rx_done;
			if (wr_hit) begin
				case (avs_address)
					`OFS_CTRL: ctrl_r <= (ctrl_r & ~be_mask) | (avs_writedata & be_mask);
					`OFS_CHCFG: chcfg_r <= (chcfg_r & ~be_mask) | (avs_writedata & be_mask);
					`OFS_STATIC_DIR: if (avs_byteenable[0]) sdir_r <= avs_writedata[7:0];
					`OFS_STATIC_OUT: if (avs_byteenable[0]) sout_r <= avs_writedata[7:0];
					`OFS_DIVIDER: div_r <= avs_writedata[15:0];
					`OFS_TX_DATA: begin
						tx_word_r <= avs_writedata[15:0];
						tx_start_r <= dir & ~tx_busy; // see RULE2
					end
					default: ;
				endcase
			end
			if (rd_hit) begin
				case (avs_address)
					`OFS_CTRL: avs_readdata <= ctrl_r;
					`OFS_CHCFG: avs_readdata <= chcfg_r;
					`OFS_STATIC_DIR: avs_readdata <= {24'h000000, sdir_r};
					`OFS_STATIC_OUT: avs_readdata <= {24'h000000, static_in_s};
					`OFS_STATUS: avs_readdata <= {26'h0000000, cts_s, rx_valid_r, tx_busy};
					`OFS_RX_DATA: avs_readdata <= {rx_word1, rx_word0};
					`OFS_DIVIDER: avs_readdata <= {16'h0000, div_r};
					default: avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign rx_sel = (rd_hit && avs_address == `OFS_RX_DATA) ? 2'h3 : 2'h0;
	////////////////////////////////////////////////////////////////////////////
	// internal bit clock and clock-line edges
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			clk_cnt_r <= 16'h0000;
			int_clk_r <= 1'b0;
			ext_clk_prev_r <= 1'b0;
		end else begin
			ext_clk_prev_r <= ext_clk_s;
			if (!loaded) begin
				clk_cnt_r <= 16'h0000;
				int_clk_r <= 1'b0; // see RULE13
			end else if (clk_cnt_r == div_r) begin
				clk_cnt_r <= 16'h0000;
				int_clk_r <= ~int_clk_r;
			end else begin
				clk_cnt_r <= clk_cnt_r + 16'h0001;
			end
		end
	end
	wire int_tick = loaded && clk_cnt_r == div_r && int_clk_r;
	wire ext_tick = ext_clk_s & ~ext_clk_prev_r;
	wire bit_tick = clk_internal ? int_tick : ext_tick; // see RULE7
	////////////////////////////////////////////////////////////////////////////
	// per-channel engines and line steering
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			wire [1:0] sel = g ? sel1 : sel0;
			wire rx_line = (sel == `LINE_RS232) ? rs232_rx_s[g] : // see RULE3
				(sel == `LINE_RS485) ? rs485_rx_s[g] : adj_in_s[g];
			wire gate = ~hs[g] | cts_s[g]; // see RULE11 RULE15
			wire [15:0] rxw;
			serial_lane lane (
				.mclk(mclk),
				.rstn(rstn),
				.enable(engine_en),
				.is_output(dir[g]),
				.sync_mode(sync_mode),
				.divider(div_r),
				.bit_tick_sync(bit_tick),
				.send_gate(gate),
				.tx_word(tx_word_r),
				.tx_start(tx_start_r[g]),
				.tx_busy(tx_busy[g]),
				.rx_word(rxw),
				.rx_done(rx_done[g]),
				.serial_in(dir[g] ? 1'b1 : rx_line),
				.serial_out(serial_tx[g])
			);
			if (g == 0) begin : w0
				assign rx_word0 = rxw;
			end else begin : w1
				assign rx_word1 = rxw;
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// registered pin drivers
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rs232_tx <= 2'h3;
			rs232_tx_oe <= 2'h3; // see RULE13
			rts <= 2'h0;
			rs485_tx <= 2'h3;
			rs485_tx_oe <= 2'h0;
			adjustable_serial_line_out <= 2'h3;
			adjustable_serial_line_oe <= 2'h0;
			line_drive_enable_n <= 2'h3;
			adjustable_clock_line_out <= 1'b0;
			adjustable_clock_line_oe <= 1'b0;
			static_io_lines_out <= 8'h00;
			static_io_lines_oe <= 8'h00;
		end else begin
			// marking level idles on rs-232 unless the configuration is loaded and the channel is an output
			rs232_tx <= serial_tx | ~(dir & {2{loaded}}); // see RULE4
			rs232_tx_oe <= 2'h3; // see RULE13
			rts <= {2{engine_en}} & ~dir & ~rx_valid_r; // see RULE10
			rs485_tx <= serial_tx;
			rs485_tx_oe <= {2{loaded}} & dir & {sel1 == `LINE_RS485, sel0 == `LINE_RS485}; // see RULE5
			adjustable_serial_line_out <= serial_tx;
			// see RULE6 RULE8
			adjustable_serial_line_oe <= {2{loaded}} & dir & {sel1 == `LINE_ADJ, sel0 == `LINE_ADJ};
			// see RULE9
			line_drive_enable_n <= ~({2{loaded}} & dir & {sel1 == `LINE_ADJ, sel0 == `LINE_ADJ});
			adjustable_clock_line_out <= int_clk_r;
			adjustable_clock_line_oe <= loaded & clk_internal; // see RULE7
			static_io_lines_out <= sout_r;
			static_io_lines_oe <= sdir_r & {8{loaded}}; // see RULE12
		end
	end
	// see RULE1: dir bits select input or output per channel
endmodule // io_steering

// ---- tb/steer_assertions.sv ----
// checker on the io steering ports
module steer_assertions (
	// clock and reset
	input wire mclk,
	input wire rstn,
	// register bus
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	// pins
	input wire [1:0] rs232_tx,
	input wire [1:0] rs232_tx_oe,
	input wire [1:0] rts,
	input wire [1:0] rs485_tx_oe,
	input wire [1:0] adjustable_serial_line_oe,
	input wire [1:0] line_drive_enable_n,
	input wire adjustable_clock_line_oe,
	input wire [7:0] static_io_lines_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	wire ack_w = avs_write & ~avs_waitrequest;
	////////////////////////////////////////////////////////////////////////
	property p_drive_en; line_drive_enable_n == ~adjustable_serial_line_oe; endproperty
	a_drive_en: assert property (p_drive_en) else $error("drive enable wrong");
	property p_rs232_oe; rs232_tx_oe == 2'h3; endproperty
	a_rs232_oe: assert property (p_rs232_oe) else $error("rs232 oe dropped");
	property p_line_excl; (rs485_tx_oe & adjustable_serial_line_oe) == 2'h0; endproperty
	a_line_excl: assert property (p_line_excl) else $error("two lines driven");
	property p_rts_dir; (rts & (rs485_tx_oe | adjustable_serial_line_oe)) == 2'h0; endproperty
	a_rts_dir: assert property (p_rts_dir) else $error("rts on output channel");
	property p_rs232_idle; (rts & ~rs232_tx) == 2'h0; endproperty
	a_rs232_idle: assert property (p_rs232_idle) else $error("tx on input channel");
	property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
	a_wait_one: assert property (p_wait_one) else $error("ack too long");
	property p_ack_cause; $fell(avs_waitrequest) |-> $past(avs_read | avs_write); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_unmapped; avs_read && !avs_waitrequest && avs_address[3] |-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_static_oe; $changed(static_io_lines_oe) |-> $past(ack_w) || $past(ack_w, 2); endproperty
	a_static_oe: assert property (p_static_oe) else $error("static oe moved alone");
	property p_clk_oe; $changed(adjustable_clock_line_oe) |-> $past(ack_w) || $past(ack_w, 2); endproperty
	a_clk_oe: assert property (p_clk_oe) else $error("clock oe moved alone");
	c_write: cover property (ack_w);
	c_read: cover property (avs_read && !avs_waitrequest);
	c_rts: cover property ($fell(rts[1]));
endmodule // steer_assertions
bind io_steering steer_assertions steer_assertions_inst (.mclk, .rstn, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .rs232_tx, .rs232_tx_oe, .rts, .rs485_tx_oe,
	.adjustable_serial_line_oe, .line_drive_enable_n, .adjustable_clock_line_oe,
	.static_io_lines_oe);

// ---- tb/serial_peer.sv ----
// far side serial equipment: clear to send and a frame sender
module serial_peer (
	input wire mclk,
	input wire [15:0] word,
	input wire go,
	input wire grant,
	output logic line,
	output logic clk_line,
	output logic [1:0] cts
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 8;
	always @(posedge mclk) cts <= {2{grant}};
	// start 0, data lsb first, stop 1; clock runs only inside the frame
	initial begin
		line = 1;
		clk_line = 0;
		forever begin
			@(posedge mclk);
			if (go) begin
				for (int i = 0; i < 18; i++) begin
					line <= (i == 0) ? 1'b0 : (i == 17) ? 1'b1 : word[i-1];
					for (int j = 0; j < P; j++) begin
						@(posedge mclk);
						if (j % 4 == 3) clk_line <= ~clk_line;
					end
				end
			end
		end
	end
endmodule // serial_peer

// ---- tb/testbench.sv ----
// self-checking bench for io steering
`include "steer_regs.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int P = 8;
	logic mclk, rstn, avs_read, avs_write, go, grant;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, rdata, noise;
	logic [15:0] word, got;
	logic [7:0] pins;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, peer_line, peer_clk, clk_oe, clk_out;
	wire [1:0] rs232_tx, rs232_tx_oe, rts, cts, rs485_tx, rs485_tx_oe, adj_out, adj_oe, den_n;
	wire [7:0] st_out, st_oe;
	integer seed = 32'hf674, num_errors = 0, comparisons = 0, cycles = 0;
	io_steering io_steering_inst (.mclk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.rs232_rx({peer_line, noise[0]}), .rs232_tx, .rs232_tx_oe, .cts, .rts,
		.rs485_rx({peer_line, noise[1]}), .rs485_tx, .rs485_tx_oe,
		.adjustable_serial_line_in({peer_line, noise[2]}), .adjustable_serial_line_out(adj_out),
		.adjustable_serial_line_oe(adj_oe), .line_drive_enable_n(den_n),
		.adjustable_clock_line_in(peer_clk), .adjustable_clock_line_out(clk_out),
		.adjustable_clock_line_oe(clk_oe), .static_io_lines_in(pins),
		.static_io_lines_out(st_out), .static_io_lines_oe(st_oe));
	serial_peer serial_peer_inst (.mclk, .word, .go, .grant, .line(peer_line),
		.clk_line(peer_clk), .cts);
	////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0) @(posedge mclk);
		rdata = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		repeat (2) @(posedge mclk);
	endtask
	function logic tx_line(input int s);
		return s == 0 ? rs232_tx[0] : s == 1 ? rs485_tx[0] : adj_out[0];
	endfunction
	// expected {adj oe, rs485 oe} with ch0 output, ch1 input
	function logic [3:0] route(input int s);
		return {1'b0, s == 2, 1'b0, s == 1};
	endfunction
	task cap(input int s);
		while (tx_line(s) !== 1'b0) @(negedge mclk);
		repeat (P + P / 2) @(negedge mclk);
		for (int i = 0; i < 16; i++) begin
			got[i] = tx_line(s);
			repeat (P) @(negedge mclk);
		end
		chk(tx_line(s), 1);
	endtask
	// peer sends a fresh word to ch1; rts drops while it waits unread
	task recv;
		@(posedge mclk);
		word = $random(seed);
		go <= 1;
		@(posedge mclk);
		go <= 0;
		repeat (19 * P) @(posedge mclk);
		chk(rts[1], 0);
		bus(0, `OFS_RX_DATA, 0);
		chk(rdata[31:16], word);
		chk(rts[1], 1);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) noise <= $random(seed);
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize;
		end
	end
	initial begin
		{rstn, avs_read, avs_write, avs_address, avs_writedata, go, grant, word, pins} = 0;
		repeat (8) @(posedge mclk);
		rstn <= 1;
		@(posedge mclk);
		chk({rs485_tx_oe, adj_oe, clk_oe, st_oe, den_n, rs232_tx_oe}, 4'hf);
		bus(0, `OFS_CHCFG, 0);
		chk(rdata, `CHCFG_RESET);
		bus(0, `OFS_DIVIDER, 0);
		chk(rdata, {16'h0, `DIVIDER_RESET});
		bus(0, 4'h9, 0);
		chk(rdata, 0);
		bus(1, `OFS_DIVIDER, P - 1);
		bus(1, `OFS_CTRL, 32'hb);
		chk(clk_oe, 1);
		got[1] = clk_out;
		repeat (P) @(posedge mclk);
		chk(clk_out, !got[1]);
		for (int s = 0; s < 3; s++) begin
			grant <= 0;
			bus(1, `OFS_CHCFG, {24'h0, s[1:0], s[1:0], 1'b0, s[0], 2'b01});
			chk({adj_oe, rs485_tx_oe}, route(s));
			chk(den_n, {1'b1, s != 2});
			chk(rts, 2'b10);
			word = $random(seed);
			bus(1, `OFS_TX_DATA, {16'h0, word});
			if (s[0]) begin
				got[0] = 1;
				repeat (40) @(negedge mclk) got[0] = got[0] & tx_line(s);
				chk(got[0], 1);
				@(posedge mclk);
				grant <= 1;
			end
			cap(s);
			chk(got, word);
			recv;
		end
		// synchronous mode on the external clock line
		bus(1, `OFS_CTRL, 32'hd);
		chk(clk_oe, 0);
		recv;
		word = $random(seed);
		pins <= word[15:8];
		bus(1, `OFS_STATIC_DIR, {24'h0, word[7:0]});
		bus(1, `OFS_STATIC_OUT, {24'h0, ~word[7:0]});
		chk({st_oe, st_out}, {word[7:0], ~word[7:0]});
		bus(0, `OFS_STATIC_OUT, 0);
		chk(rdata[7:0], word[15:8]);
		bus(1, `OFS_CTRL, 32'h7);
		bus(0, `OFS_CTRL, 0);
		chk(rdata[2:0], 3'h7);
		summarize;
	end
endmodule // testbench
